// >>> pkg/psra_defines.vh
// Constants for the paged shared RAM access unit
`ifndef PSRA_DEFINES_VH
`define PSRA_DEFINES_VH

// Window in the global address space
`define PSRA_WIN_LO 33'h0000FF400
`define PSRA_WIN_HI 33'h0000FFBFF
`define PSRA_LIM_WORD 33'h0000FFBFE
`define PSRA_LIM_DWORD 33'h0000FFBFC

// Page numbers
`define PSRA_PAGE_MAX 16'h00FF
`define PSRA_PAGE_RST 8'h00

// Operation codes
`define PSRA_OP_OPEN 4'h0
`define PSRA_OP_TAS 4'h1
`define PSRA_OP_LDB_B 4'h2
`define PSRA_OP_LDW_B 4'h3
`define PSRA_OP_LDD_B 4'h4
`define PSRA_OP_STB_B 4'h5
`define PSRA_OP_STW_B 4'h6
`define PSRA_OP_STD_B 4'h7
`define PSRA_OP_LDW_W 4'h8
`define PSRA_OP_LDD_W 4'h9
`define PSRA_OP_STW_W 4'hA
`define PSRA_OP_STD_W 4'hB

// Backplane access sizes
`define PSRA_SZ_BYTE 2'h0
`define PSRA_SZ_WORD 2'h1
`define PSRA_SZ_DWORD 2'h2

// Free occupancy byte
`define PSRA_FREE 8'h00

`endif

// >>> rtl/psra_access.v
// Paged shared RAM access unit: page register, test-and-set, paged loads and transfers

`default_nettype none

`include "psra_defines.vh"

module psra_access (
  // Clock and reset
  input wire clk_sys,
  input wire reset,
  // Operation request from the instruction sequencer
  input wire op_valid,
  input wire [3:0] op_code,
  input wire [15:0] op_const,
  output wire op_ready,
  output reg op_done,
  // Processor state
  input wire [31:0] base_pointer_reg,
  input wire [31:0] accum_first,
  input wire [7:0] slot_id,
  output reg [31:0] accum_first_new,
  output reg [31:0] accum_second,
  output reg accum_write,
  output reg cond_code_low,
  output reg cond_code_high,
  output reg [7:0] page_reg,
  // Fault handling
  input wire subst_handler_loaded,
  input wire xfer_handler_loaded,
  output reg substitution_fault,
  output reg transfer_fault,
  output reg substitution_fault_handler,
  output reg transfer_fault_handler,
  output reg stop_mode,
  output reg interrupt_stack_record,
  output wire interrupt_block,
  // Backplane access port
  output reg bus_req,
  output reg bus_sel,
  output reg bus_we,
  output reg [1:0] bus_size,
  output reg [19:0] bus_addr,
  output reg [31:0] bus_wdata,
  input wire bus_ack,
  input wire bus_err,
  input wire [31:0] bus_rdata
);

  ////////////////////////////////////////////////////////////////////////////
  // States, one-hot

  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_SEL = 4'h2;
  localparam [3:0] ST_ACC = 4'h4;
  localparam [3:0] ST_TSW = 4'h8;

  reg [3:0] state;
  reg [3:0] op_hold;
  reg [19:0] addr_hold;
  reg [31:0] acc_hold;
  reg [7:0] slot_hold;

  ////////////////////////////////////////////////////////////////////////////
  // Address and range decode

  wire [32:0] sum_addr;
  wire [32:0] ext_const;
  reg [32:0] lim;
  reg [1:0] size;
  reg is_store;
  reg is_load;
  wire in_range;
  wire page_bad;
  wire take;

  assign ext_const = {{17{op_const[15]}}, op_const};
  assign sum_addr = {1'b0, base_pointer_reg} + ext_const;

  always @* begin
    lim = `PSRA_WIN_HI;
    size = `PSRA_SZ_WORD;
    is_store = 1'b0;
    is_load = 1'b0;
    case (op_code)
      `PSRA_OP_LDB_B: begin
        size = `PSRA_SZ_BYTE;
        is_load = 1'b1;
      end
      `PSRA_OP_STB_B: begin
        size = `PSRA_SZ_BYTE;
        is_store = 1'b1;
      end
      `PSRA_OP_LDW_B: begin
        lim = `PSRA_LIM_WORD;
        is_load = 1'b1;
      end
      `PSRA_OP_STW_B: begin
        lim = `PSRA_LIM_WORD;
        is_store = 1'b1;
      end
      `PSRA_OP_LDD_B: begin
        lim = `PSRA_LIM_DWORD;
        size = `PSRA_SZ_DWORD;
        is_load = 1'b1;
      end
      `PSRA_OP_STD_B: begin
        lim = `PSRA_LIM_DWORD;
        size = `PSRA_SZ_DWORD;
        is_store = 1'b1;
      end
      `PSRA_OP_LDW_W: begin
        is_load = 1'b1;
      end
      `PSRA_OP_STW_W: begin
        is_store = 1'b1;
      end
      `PSRA_OP_LDD_W: begin
        lim = `PSRA_LIM_WORD;
        size = `PSRA_SZ_DWORD;
        is_load = 1'b1;
      end
      `PSRA_OP_STD_W: begin
        lim = `PSRA_LIM_WORD;
        size = `PSRA_SZ_DWORD;
        is_store = 1'b1;
      end
      default: begin
        lim = `PSRA_WIN_HI;
      end
    endcase
  end

  // Decided on the request cycle, before any bus cycle can start
  assign in_range = (sum_addr >= `PSRA_WIN_LO) && (sum_addr <= lim);
  assign page_bad = accum_first[15:0] > `PSRA_PAGE_MAX;
  assign op_ready = (state == ST_IDLE) && !stop_mode;
  assign take = op_valid && op_ready;

  // Interrupts held off for the whole select-plus-access sequence
  assign interrupt_block = (state != ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state <= ST_IDLE;
      op_hold <= `PSRA_OP_OPEN;
      addr_hold <= 20'h00000;
      acc_hold <= 32'h00000000;
      slot_hold <= 8'h00;
      op_done <= 1'b0;
      accum_first_new <= 32'h00000000;
      accum_second <= 32'h00000000;
      accum_write <= 1'b0;
      cond_code_low <= 1'b0;
      cond_code_high <= 1'b0;
      page_reg <= `PSRA_PAGE_RST;
      substitution_fault <= 1'b0;
      transfer_fault <= 1'b0;
      substitution_fault_handler <= 1'b0;
      transfer_fault_handler <= 1'b0;
      stop_mode <= 1'b0;
      interrupt_stack_record <= 1'b0;
      bus_req <= 1'b0;
      bus_sel <= 1'b0;
      bus_we <= 1'b0;
      bus_size <= `PSRA_SZ_BYTE;
      bus_addr <= 20'h00000;
      bus_wdata <= 32'h00000000;
    end else begin
      op_done <= 1'b0;
      accum_write <= 1'b0;
      substitution_fault <= 1'b0;
      transfer_fault <= 1'b0;
      substitution_fault_handler <= 1'b0;
      transfer_fault_handler <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (take) begin
            op_hold <= op_code;
            addr_hold <= sum_addr[19:0];
            acc_hold <= accum_first;
            slot_hold <= slot_id;
            if (op_code == `PSRA_OP_OPEN) begin
              op_done <= 1'b1;
              if (page_bad) begin
                substitution_fault <= 1'b1;
                substitution_fault_handler <= subst_handler_loaded;
                stop_mode <= !subst_handler_loaded;
              end else begin
                page_reg <= accum_first[7:0];
              end
            end else if (!in_range || op_code > `PSRA_OP_STD_W) begin
              // Nothing reaches the backplane on a fault
              op_done <= 1'b1;
              transfer_fault <= 1'b1;
              transfer_fault_handler <= xfer_handler_loaded;
              stop_mode <= !xfer_handler_loaded;
              interrupt_stack_record <= !xfer_handler_loaded;
            end else begin
              bus_req <= 1'b1;
              bus_sel <= 1'b1;
              bus_we <= 1'b1;
              bus_size <= `PSRA_SZ_BYTE;
              bus_addr <= 20'h00000;
              bus_wdata <= {24'h000000, page_reg};
              state <= ST_SEL;
            end
          end
        end
        ST_SEL: begin
          if (bus_ack) begin
            // Access follows the select write with no gap
            bus_sel <= 1'b0;
            bus_addr <= addr_hold;
            if (op_hold == `PSRA_OP_TAS) begin
              bus_we <= 1'b0;
              bus_size <= `PSRA_SZ_WORD;
              bus_wdata <= 32'h00000000;
            end else begin
              bus_we <= is_st(op_hold);
              bus_size <= size_of(op_hold);
              bus_wdata <= data_of(op_hold, acc_hold);
            end
            state <= ST_ACC;
          end
        end
        ST_ACC: begin
          if (bus_ack) begin
            if (bus_err) begin
              bus_req <= 1'b0;
              op_done <= 1'b1;
              transfer_fault <= 1'b1;
              transfer_fault_handler <= xfer_handler_loaded;
              stop_mode <= !xfer_handler_loaded;
              interrupt_stack_record <= !xfer_handler_loaded;
              state <= ST_IDLE;
            end else if (op_hold == `PSRA_OP_TAS) begin
              if (bus_rdata[7:0] == `PSRA_FREE) begin
                // Claim while the bus is still held
                bus_we <= 1'b1;
                bus_size <= `PSRA_SZ_BYTE;
                bus_wdata <= {24'h000000, slot_hold};
                cond_code_high <= 1'b0;
                cond_code_low <= 1'b0;
                state <= ST_TSW;
              end else begin
                bus_req <= 1'b0;
                op_done <= 1'b1;
                cond_code_high <= (bus_rdata[7:0] == slot_hold);
                cond_code_low <= (bus_rdata[7:0] != slot_hold);
                state <= ST_IDLE;
              end
            end else begin
              bus_req <= 1'b0;
              bus_we <= 1'b0;
              op_done <= 1'b1;
              if (!is_st(op_hold)) begin
                accum_write <= 1'b1;
                accum_second <= acc_hold;
                accum_first_new <= load_of(op_hold, bus_rdata);
              end
              state <= ST_IDLE;
            end
          end
        end
        ST_TSW: begin
          if (bus_ack) begin
            bus_req <= 1'b0;
            bus_we <= 1'b0;
            op_done <= 1'b1;
            if (bus_err) begin
              transfer_fault <= 1'b1;
              transfer_fault_handler <= xfer_handler_loaded;
              stop_mode <= !xfer_handler_loaded;
              interrupt_stack_record <= !xfer_handler_loaded;
            end
            state <= ST_IDLE;
          end
        end
        default: begin
          bus_req <= 1'b0;
          state <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-operation helpers

  function is_st;
    input [3:0] op;
    begin
      is_st = (op == `PSRA_OP_STB_B) || (op == `PSRA_OP_STW_B) || (op == `PSRA_OP_STD_B) ||
        (op == `PSRA_OP_STW_W) || (op == `PSRA_OP_STD_W);
    end
  endfunction

  function [1:0] size_of;
    input [3:0] op;
    begin
      case (op)
        `PSRA_OP_LDB_B, `PSRA_OP_STB_B: size_of = `PSRA_SZ_BYTE;
        `PSRA_OP_LDD_B, `PSRA_OP_STD_B, `PSRA_OP_LDD_W, `PSRA_OP_STD_W: size_of = `PSRA_SZ_DWORD;
        default: size_of = `PSRA_SZ_WORD;
      endcase
    end
  endfunction

  // Unused lanes driven low so a module never sees stale upper bytes
  function [31:0] data_of;
    input [3:0] op;
    input [31:0] acc;
    begin
      case (size_of(op))
        `PSRA_SZ_BYTE: data_of = {24'h000000, acc[7:0]};
        `PSRA_SZ_WORD: data_of = {16'h0000, acc[15:0]};
        default: data_of = acc;
      endcase
    end
  endfunction

  function [31:0] load_of;
    input [3:0] op;
    input [31:0] rd;
    begin
      case (size_of(op))
        `PSRA_SZ_BYTE: load_of = {24'h000000, rd[7:0]};
        `PSRA_SZ_WORD: load_of = {16'h0000, rd[15:0]};
        default: load_of = rd;
      endcase
    end
  endfunction

  // Unused decode outputs kept for readability of the request-cycle check
  wire unused_ok;
  assign unused_ok = is_store | is_load | size[0];

endmodule

`default_nettype wire

// >>> dv/psra_checker.sv
// Port checker for the paged shared RAM access unit
`default_nettype none
module psra_checker (
  // Clock and reset
  input wire clk_sys,
  input wire reset,
  // Operation status
  input wire op_ready,
  input wire [7:0] page_reg,
  input wire substitution_fault,
  input wire transfer_fault,
  input wire transfer_fault_handler,
  input wire stop_mode,
  input wire interrupt_block,
  // Backplane
  input wire bus_req,
  input wire bus_sel,
  input wire bus_ack,
  input wire [19:0] bus_addr,
  input wire [31:0] bus_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////
  sequence s_sel_ack;
    bus_req && bus_sel && bus_ack;
  endsequence
  sequence s_access;
    bus_req && !bus_sel;
  endsequence
  chk_select_first: assert property ($rose(bus_req) |-> bus_sel && bus_wdata[7:0] == page_reg)
    else $error("no select write first");
  chk_request_held: assert property (bus_req && !bus_ack |=> bus_req && $stable(bus_sel) && $stable(bus_addr))
    else $error("request dropped early");
  chk_access_follows: assert property (s_sel_ack |=> s_access)
    else $error("no access after select");
  chk_page_kept: assert property (bus_req |-> $stable(page_reg))
    else $error("page changed in access");
  chk_window_addr: assert property (s_access |-> bus_addr >= 20'hFF400 && bus_addr <= 20'hFFBFF)
    else $error("address out of window");
  chk_subst_quiet: assert property (substitution_fault |-> !bus_req && !$past(bus_req))
    else $error("bus used on bad page");
  chk_handler_cause: assert property (transfer_fault_handler |-> transfer_fault)
    else $error("handler without fault");
  chk_stop_sticky: assert property (stop_mode |=> stop_mode && !op_ready)
    else $error("stop mode left");
  // Any bus cycle in flight must keep interrupts out, select and TAS write included
  chk_irq_held: assert property (bus_req |-> interrupt_block)
    else $error("interrupts open in access");
endmodule
bind psra_access psra_checker u_chk (
  .clk_sys(clk_sys),
  .reset(reset),
  .op_ready(op_ready),
  .page_reg(page_reg),
  .substitution_fault(substitution_fault),
  .transfer_fault(transfer_fault),
  .transfer_fault_handler(transfer_fault_handler),
  .stop_mode(stop_mode),
  .interrupt_block(interrupt_block),
  .bus_req(bus_req),
  .bus_sel(bus_sel),
  .bus_ack(bus_ack),
  .bus_addr(bus_addr),
  .bus_wdata(bus_wdata)
);
`default_nettype wire

// >>> dv/psra_dpram.sv
// Behavioural dual-port RAM modules with their select register
`default_nettype none
module psra_dpram (
  // Clock
  input wire logic clk_sys,
  // Backplane
  input wire logic bus_req,
  input wire logic bus_sel,
  input wire logic bus_we,
  input wire logic [1:0] bus_size,
  input wire logic [19:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  output logic bus_ack = 1'h0,
  output logic bus_err,
  output logic [31:0] bus_rdata = 32'h5A5A0F0F,
  // Test control
  input wire logic [1:0] slow,
  input wire logic err_on
);
  timeunit 1ns;
  timeprecision 1ps;
  bit [31:0] m[int];
  logic [7:0] pg = 8'h00;
  // Size of the last data cycle, read back by the bench
  logic [1:0] sz = 2'h0;
  int n = 0;
  int key;
  logic hit;
  // Only data cycles fail, as for a module that is absent
  assign bus_err = bus_ack && err_on && !bus_sel;
  always @(posedge clk_sys) begin
    hit = bus_req && bus_ack;
    key = {pg, 11'(bus_addr - 20'hFF400)};
    if (hit && !bus_sel) sz = bus_size;
    if (hit && bus_sel) pg = bus_wdata[7:0];
    else if (hit && bus_we && !err_on) m[key] = bus_wdata;
    #1;
    n = (hit || !bus_req) ? 0 : n + 1;
    bus_ack = bus_req && n >= slow;
    // Idle lanes flip each cycle so stale data never looks valid
    bus_rdata = bus_ack ? m[{pg, 11'(bus_addr - 20'hFF400)}] : ~bus_rdata;
  end
endmodule
`default_nettype wire

// >>> dv/paged_shared_ram_access_tb.sv
// Self-checking bench for the paged shared RAM access unit
`default_nettype none
module paged_shared_ram_access_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, reset = 1, op_valid = 0, err_on = 0;
  logic subst_handler_loaded = 1, xfer_handler_loaded = 1;
  logic [3:0] op_code = 0, g;
  logic [15:0] op_const = 0;
  logic [31:0] base_pointer_reg = 0, accum_first = 0, r = 32'h40928390;
  logic [7:0] slot_id = 8'h2C, pg = 0;
  logic [1:0] slow = 0;
  wire op_ready, op_done, accum_write, cond_code_low, cond_code_high, substitution_fault, transfer_fault;
  wire substitution_fault_handler, transfer_fault_handler, stop_mode, interrupt_stack_record, interrupt_block;
  wire bus_req, bus_sel, bus_we, bus_ack, bus_err;
  wire [1:0] bus_size;
  wire [19:0] bus_addr;
  wire [31:0] accum_first_new, accum_second, bus_wdata, bus_rdata;
  wire [7:0] page_reg;
  bit [31:0] ref_m[int];
  integer errors = 0, check_count = 0, cyc = 0;
  psra_access dut (
    .clk_sys(clk_sys), .reset(reset), .op_valid(op_valid), .op_code(op_code), .op_const(op_const),
    .op_ready(op_ready), .op_done(op_done), .base_pointer_reg(base_pointer_reg), .accum_first(accum_first),
    .slot_id(slot_id), .accum_first_new(accum_first_new), .accum_second(accum_second),
    .accum_write(accum_write), .cond_code_low(cond_code_low), .cond_code_high(cond_code_high),
    .page_reg(page_reg), .subst_handler_loaded(subst_handler_loaded), .xfer_handler_loaded(xfer_handler_loaded),
    .substitution_fault(substitution_fault), .transfer_fault(transfer_fault),
    .substitution_fault_handler(substitution_fault_handler), .transfer_fault_handler(transfer_fault_handler),
    .stop_mode(stop_mode), .interrupt_stack_record(interrupt_stack_record), .interrupt_block(interrupt_block),
    .bus_req(bus_req), .bus_sel(bus_sel), .bus_we(bus_we), .bus_size(bus_size), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_ack(bus_ack), .bus_err(bus_err), .bus_rdata(bus_rdata)
  );
  psra_dpram dp (
    .clk_sys(clk_sys), .bus_req(bus_req), .bus_sel(bus_sel), .bus_we(bus_we), .bus_size(bus_size),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_ack(bus_ack), .bus_err(bus_err), .bus_rdata(bus_rdata),
    .slow(slow), .err_on(err_on)
  );
  ////////////////////////////////////////////////////////////////
  initial forever #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (++cyc == 30000) begin
    errors++;
    close_out;
  end
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [32:0] lim(input logic [3:0] c);
    return (c == 3 || c == 6 || c == 9 || c == 11) ? 33'hFFBFE : (c == 4 || c == 7) ? 33'hFFBFC : 33'hFFBFF;
  endfunction
  task chk(input string n, input logic [31:0] e, input logic [31:0] v);
    check_count++;
    if (v !== e) begin
      errors++;
      $display("MISMATCH %s exp %h got %h", n, e, v);
    end
  endtask
  task close_out;
    if (errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  task op(input logic [3:0] c, input logic [31:0] b, input logic [15:0] k, input logic [31:0] a);
    integer i;
    g = 0;
    for (i = 0; i < 50 && op_ready !== 1; i++) @(posedge clk_sys) #1;
    op_valid = 1;
    op_code = c;
    base_pointer_reg = b;
    op_const = k;
    accum_first = a;
    @(posedge clk_sys) #1;
    op_valid = 0;
    for (i = 0; i < 60; i++) begin
      g = g | {substitution_fault_handler, substitution_fault, transfer_fault_handler, transfer_fault};
      if (op_done === 1) break;
      @(posedge clk_sys) #1;
    end
    chk("done", 1, op_done);
  endtask
  // One paged access with a random signed constant, checked against the model
  task xs(input logic [3:0] c, input logic [32:0] a);
    logic [15:0] k;
    logic [31:0] d, m;
    logic [7:0] b;
    logic ok;
    int key;
    r = nx(r);
    k = r[15:0];
    slow = r[17:16];
    r = nx(r);
    d = r;
    m = (c == 2 || c == 5) ? 32'hFF : (c == 3 || c == 6 || c == 8 || c == 10) ? 32'hFFFF : 32'hFFFFFFFF;
    key = {pg, 11'(a[19:0] - 20'hFF400)};
    ok = a >= 33'hFF400 && a <= lim(c) && !err_on;
    op(c, a[31:0] - {{16{k[15]}}, k}, k, d);
    chk("fault", !ok, g[0]);
    chk("handler", !ok && xfer_handler_loaded, g[1]);
    chk("write", ok && (c == 2 || c == 3 || c == 4 || c == 8 || c == 9), accum_write);
    if (!ok) return;
    if (c != 1) chk("size",
      (c == 2 || c == 5) ? 0 : (c == 4 || c == 7 || c == 9 || c == 11) ? 2 : 1, dp.sz);
    b = ref_m[key][7:0];
    if (c == 1) begin
      chk("codes", b == 0 ? 0 : b == slot_id ? 2 : 1, {cond_code_high, cond_code_low});
      if (b == 0) ref_m[key] = slot_id;
    end else if (c == 5 || c == 6 || c == 7 || c > 9) ref_m[key] = d & m;
    else begin
      chk("load", ref_m[key] & m, accum_first_new);
      chk("second", d, accum_second);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    static logic [3:0] st[5] = '{4'h5, 4'h6, 4'h7, 4'hA, 4'hB};
    static logic [3:0] ld[5] = '{4'h2, 4'h3, 4'h4, 4'h8, 4'h9};
    logic [32:0] a;
    integer i;
    repeat (6) @(posedge clk_sys);
    #1;
    reset = 0;
    op(0, 0, 0, 32'h100);
    chk("page", 0, page_reg);
    chk("subst", 4'hC, g);
    op(0, 0, 0, 32'hFFFF0011);
    pg = 8'h11;
    chk("page", pg, page_reg);
    for (i = 0; i < 40; i++) begin
      r = nx(r);
      a = 33'hFF3F8 + r[11:0] % 12'h810;
      xs(st[i % 5], a);
      xs(ld[i % 5], a);
      if (i == 20) op(0, 0, 0, 32'hC8);
      if (i == 20) pg = 8'hC8;
    end
    for (i = 2; i < 12; i++) begin
      xs(4'(i), lim(4'(i)));
      xs(4'(i), lim(4'(i)) + 1);
      xs(4'(i), 33'hFF3FF);
    end
    a = 33'hFF500;
    xs(1, a);
    xs(1, a);
    dp.m[{pg, 11'h100}] = 32'h33;
    ref_m[{pg, 11'h100}] = 32'h33;
    xs(1, a);
    dp.m[{pg, 11'h100}] = 0;
    ref_m[{pg, 11'h100}] = 0;
    xs(1, a);
    xs(1, 33'hFFC00);
    xs(1, 33'hFF3FE);
    op(4'hD, 32'hFF600, 0, 0);
    chk("undef", 4'h3, g);
    err_on = 1;
    xs(1, 33'hFF600);
    xs(2, 33'hFF600);
    err_on = 0;
    xfer_handler_loaded = 0;
    xs(3, 33'hFFBFF);
    @(posedge clk_sys) #1;
    chk("stop", 1, stop_mode);
    chk("record", 1, interrupt_stack_record);
    chk("ready", 0, op_ready);
    reset = 1;
    @(posedge clk_sys) #1;
    reset = 0;
    chk("page", 0, page_reg);
    subst_handler_loaded = 0;
    op(0, 0, 0, 32'h1FF);
    @(posedge clk_sys) #1;
    chk("subst", 4'h4, g);
    chk("stop", 1, stop_mode);
    chk("record", 0, interrupt_stack_record);
    close_out;
  end
endmodule
`default_nettype wire
